//--- phy_next_page_aux_regs.sv
// next-page, analog front-end control and symbol error counter registers
`timescale 1ns/1ps
`default_nettype none
module phy_next_page_aux_regs (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        partner_page_valid_i,
  input  wire logic [15:0] partner_page_i,
  input  wire logic        receive_error_indication_i,
  output logic      [10:0] local_message_field_o,
  output logic             slow_osc_select_o,
  output logic             analog_front_end_power_down_o
);

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction

  logic [10:0] local_msg_q;
  logic [10:0] local_msg_d;
  logic [15:0] partner_q;
  logic [15:0] partner_d;
  logic [15:0] analog_ctrl_q;
  logic [15:0] analog_ctrl_d;
  logic [15:0] err_cnt_q;
  logic [15:0] err_cnt_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        err_rd;
  logic [15:0] err_base;
  logic        err_full;
  logic        sel_local;
  logic        sel_partner;
  logic        sel_analog;
  logic        sel_err;
  logic        wr_local;
  logic        wr_analog;
  logic        slow_osc_on;
  logic [15:0] local_word;

  // one address decode shared by the write, read and clear paths
  always_comb
  begin
    sel_local = hit(reg_addr_i, phy_next_page_aux_pkg::LOCAL_NEXT_PAGE_OFF);
    sel_partner = hit(reg_addr_i, phy_next_page_aux_pkg::PARTNER_NEXT_PAGE_OFF);
    sel_analog = hit(reg_addr_i, phy_next_page_aux_pkg::ANALOG_CTRL_OFF);
    sel_err = hit(reg_addr_i, phy_next_page_aux_pkg::SYMBOL_ERR_CNT_OFF);
  end

  // write strobes per register; read-only offsets never get one
  always_comb
  begin
    wr_local = reg_wr_i && sel_local;
    wr_analog = reg_wr_i && sel_analog;
  end

  // a read of the counter doubles as its clear
  always_comb
  begin
    err_rd = reg_rd_i && sel_err;
  end

  always_comb
  begin
    local_msg_d = local_msg_q;
    if (wr_local)
    begin
      local_msg_d = reg_wdata_i[10:0];
    end
  end

  // captured page from the auto-negotiation engine
  always_comb
  begin
    partner_d = partner_q;
    if (partner_page_valid_i)
    begin
      partner_d[phy_next_page_aux_pkg::PARTNER_MORE_PAGES_BIT] =
        partner_page_i[phy_next_page_aux_pkg::PARTNER_MORE_PAGES_BIT];
      partner_d[phy_next_page_aux_pkg::PARTNER_ACK_BIT] =
        partner_page_i[phy_next_page_aux_pkg::PARTNER_ACK_BIT];
      partner_d[phy_next_page_aux_pkg::PARTNER_MSG_PAGE_BIT] =
        partner_page_i[phy_next_page_aux_pkg::PARTNER_MSG_PAGE_BIT];
      partner_d[phy_next_page_aux_pkg::PARTNER_ACK2_BIT] =
        partner_page_i[phy_next_page_aux_pkg::PARTNER_ACK2_BIT];
      partner_d[phy_next_page_aux_pkg::PARTNER_TOGGLE_BIT] =
        partner_page_i[phy_next_page_aux_pkg::PARTNER_TOGGLE_BIT];
      partner_d[phy_next_page_aux_pkg::MSG_W-1:0] =
        partner_page_i[phy_next_page_aux_pkg::MSG_W-1:0];
    end
  end

  always_comb
  begin
    analog_ctrl_d = analog_ctrl_q;
    if (wr_analog)
    begin
      analog_ctrl_d = reg_wdata_i;
    end
  end

  // read clears; an error in the same cycle still counts
  always_comb
  begin
    err_base = err_rd ? phy_next_page_aux_pkg::ERR_CNT_RESET : err_cnt_q;
    err_full = (err_base == phy_next_page_aux_pkg::ERR_CNT_MAX);
    err_cnt_d = err_base;
    if (receive_error_indication_i && !err_full)
    begin
      err_cnt_d = err_base + 16'h0001;
    end
  end

  // bits above the message field are not kept and read as zero
  always_comb
  begin
    local_word = 16'h0000;
    local_word[phy_next_page_aux_pkg::MSG_W-1:0] = local_msg_q;
  end

  // read data stands one cycle, idle value zero
  always_comb
  begin
    rdata_d = 16'h0000;
    if (reg_rd_i)
    begin
      if (sel_local)
      begin
        rdata_d = local_word;
      end
      else if (sel_partner)
      begin
        rdata_d = partner_q;
      end
      else if (sel_analog)
      begin
        rdata_d = analog_ctrl_q;
      end
      else if (err_rd)
      begin
        rdata_d = err_cnt_q;
      end
      else
      begin
        rdata_d = 16'h0000;
      end
    end
  end

  // local message field register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      local_msg_q <= phy_next_page_aux_pkg::LOCAL_MSG_RESET;
    end
    else
    begin
      local_msg_q <= local_msg_d;
    end
  end

  // captured partner page register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      partner_q <= phy_next_page_aux_pkg::PARTNER_RESET;
    end
    else
    begin
      partner_q <= partner_d;
    end
  end

  // analog control register
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      analog_ctrl_q <= phy_next_page_aux_pkg::ANALOG_CTRL_RESET;
    end
    else
    begin
      analog_ctrl_q <= analog_ctrl_d;
    end
  end

  // symbol error frame counter
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      err_cnt_q <= phy_next_page_aux_pkg::ERR_CNT_RESET;
    end
    else
    begin
      err_cnt_q <= err_cnt_d;
    end
  end

  // registered read data
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_q <= 16'h0000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign local_message_field_o = local_msg_q;
  assign slow_osc_on = analog_ctrl_q[phy_next_page_aux_pkg::SLOW_OSC_BIT];
  // the analog side follows the oscillator choice with no second write
  assign slow_osc_select_o = slow_osc_on;
  assign analog_front_end_power_down_o = slow_osc_on;

endmodule
`default_nettype wire

//--- phy_next_page_aux_pkg.sv
// constants for the next-page, analog front-end and symbol error registers
`default_nettype none
package phy_next_page_aux_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  localparam logic [4:0] LOCAL_NEXT_PAGE_OFF = 5'h07;
  localparam logic [4:0] PARTNER_NEXT_PAGE_OFF = 5'h08;
  localparam logic [4:0] ANALOG_CTRL_OFF = 5'h11;
  localparam logic [4:0] SYMBOL_ERR_CNT_OFF = 5'h15;

  localparam int unsigned MSG_W = 11;
  localparam logic [10:0] LOCAL_MSG_RESET = 11'h001;
  localparam logic [15:0] PARTNER_RESET = 16'h0000;
  localparam logic [15:0] ANALOG_CTRL_RESET = 16'h0000;
  localparam logic [15:0] ERR_CNT_RESET = 16'h0000;
  localparam logic [15:0] ERR_CNT_MAX = 16'hffff;

  localparam int unsigned PARTNER_MORE_PAGES_BIT = 15;
  localparam int unsigned PARTNER_ACK_BIT = 14;
  localparam int unsigned PARTNER_MSG_PAGE_BIT = 13;
  localparam int unsigned PARTNER_ACK2_BIT = 12;
  localparam int unsigned PARTNER_TOGGLE_BIT = 11;
  localparam int unsigned SLOW_OSC_BIT = 5;
endpackage
`default_nettype wire

//--- an_peer.sv
// far-side model: partner page captures and symbol error pulses
`timescale 1ns/1ps
`default_nettype none
module an_peer (
  input  wire logic        mclk_i,
  output logic             page_valid_o,
  output logic      [15:0] page_o,
  output logic             err_o
);
  initial {page_valid_o, page_o, err_o} = '0;
  task automatic send(input logic [15:0] w);
    @(posedge mclk_i);
    page_valid_o <= 1'b1;
    page_o <= w;
    @(posedge mclk_i);
    page_valid_o <= 1'b0;
    page_o <= ~w;
  endtask
  task automatic errs(input int n);
    repeat (n) @(posedge mclk_i) err_o <= 1'b1;
    @(posedge mclk_i) err_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- phy_aux_regs_assertions.sv
// port checker for the next-page, analog control and error counter registers
`timescale 1ns/1ps
`default_nettype none
module phy_aux_regs_chk (
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic [4:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        partner_page_valid_i,
  input wire logic [15:0] partner_page_i,
  input wire logic        receive_error_indication_i,
  input wire logic [10:0] local_message_field_o,
  input wire logic        slow_osc_select_o,
  input wire logic        analog_front_end_power_down_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  msg_write_a: assert property (reg_wr_i && reg_addr_i == 5'h07 |=>
    local_message_field_o == $past(reg_wdata_i[10:0])) else $error("bad write");
  msg_hold_a: assert property (!(reg_wr_i && reg_addr_i == 5'h07) |=>
    $stable(local_message_field_o)) else $error("bad hold");
  msg_read_a: assert property (reg_rd_i && reg_addr_i == 5'h07 |=>
    reg_rdata_o == {5'h00, $past(local_message_field_o)}) else $error("bad read");
  osc_write_a: assert property (reg_wr_i && reg_addr_i == 5'h11 |=>
    slow_osc_select_o == $past(reg_wdata_i[5])) else $error("bad osc");
  osc_read_a: assert property (reg_rd_i && reg_addr_i == 5'h11 |=>
    reg_rdata_o[5] == $past(slow_osc_select_o)) else $error("bad osc read");
  power_tie_a: assert property (slow_osc_select_o ==
    analog_front_end_power_down_o) else $error("bad power down");
  page_read_a: assert property (partner_page_valid_i ##1 !partner_page_valid_i
    ##1 (reg_rd_i && reg_addr_i == 5'h08 && !partner_page_valid_i) |=>
    reg_rdata_o == $past(partner_page_i, 3)) else $error("bad page");
  count_clear_a: assert property ((reg_rd_i && reg_addr_i == 5'h15 &&
    !receive_error_indication_i) ##1 !receive_error_indication_i
    ##1 (reg_rd_i && reg_addr_i == 5'h15) |=> reg_rdata_o == 16'h0000)
    else $error("bad clear");
  count_keep_a: assert property ((reg_rd_i && reg_addr_i == 5'h15 &&
    receive_error_indication_i) ##1 !receive_error_indication_i
    ##1 (reg_rd_i && reg_addr_i == 5'h15) |=> reg_rdata_o == 16'h0001)
    else $error("bad keep");
endmodule
bind phy_next_page_aux_regs phy_aux_regs_chk u_chk (
  .mclk_i(mclk_i),
  .reset_n_i(reset_n_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .partner_page_valid_i(partner_page_valid_i),
  .partner_page_i(partner_page_i),
  .receive_error_indication_i(receive_error_indication_i),
  .local_message_field_o(local_message_field_o),
  .slow_osc_select_o(slow_osc_select_o),
  .analog_front_end_power_down_o(analog_front_end_power_down_o)
);
`default_nettype wire

//--- tb_phy_next_page_aux_regs.sv
// bench for the next-page, analog control and error counter registers
`timescale 1ns/1ps
`default_nettype none
module tb_phy_next_page_aux_regs;
  logic        mclk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, pv, er, so, pd;
  logic [4:0]  reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, pg;
  logic [10:0] lm;
  int          errors = 0, checks = 0, cyc = 0;
  always #12.5 mclk_i = ~mclk_i;
  an_peer peer (.mclk_i, .page_valid_o(pv), .page_o(pg), .err_o(er));
  phy_next_page_aux_regs DUT (.mclk_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .partner_page_valid_i(pv), .partner_page_i(pg),
    .receive_error_indication_i(er), .local_message_field_o(lm), .slow_osc_select_o(so),
    .analog_front_end_power_down_o(pd));
  task automatic chk(input logic [15:0] g, e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(reg_rdata_o, e);
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_i)
    if (++cyc == 3000)
    begin
      errors++;
      results();
    end
  initial
  begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(5'h07, 16'h0001);
    rd(5'h08, 16'h0000);
    rd(5'h15, 16'h0000);
    rd(5'h1f, 16'h0000);
    wr(5'h07, 16'hffff);
    rd(5'h07, 16'h07ff);
    chk({5'h00, lm}, 16'h07ff);
    peer.send(16'hd555);
    rd(5'h08, 16'hd555);
    peer.send(16'h2aaa);
    rd(5'h08, 16'h2aaa);
    wr(5'h08, 16'hffff);
    rd(5'h08, 16'h2aaa);
    peer.errs(3);
    rd(5'h15, 16'h0003);
    rd(5'h15, 16'h0000);
    wr(5'h15, 16'hffff);
    peer.errs(1);
    fork
      peer.errs(1);
      rd(5'h15, 16'h0001);
    join
    rd(5'h15, 16'h0001);
    wr(5'h11, 16'h0020);
    chk({14'h0000, so, pd}, 16'h0003);
    rd(5'h11, 16'h0020);
    wr(5'h11, 16'h0000);
    chk({14'h0000, so, pd}, 16'h0000);
    wr(5'h07, 16'h0555);
    wr(5'h11, 16'h0020);
    peer.errs(2);
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(5'h07, 16'h0001);
    chk({5'h00, lm}, 16'h0001);
    rd(5'h08, 16'h0000);
    rd(5'h15, 16'h0000);
    chk({14'h0000, so, pd}, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
